/* src/lsc_pkg.sv */
// constants shared by the lamp switch mode control block
//
// Behaviour
// - serial output released while chip select high; driven once chip select low
// - serial output changes on serial clock rise; host samples on the fall
// - watchdog enabled while fail-safe select input high, disabled when grounded
// - after enabled watchdog timeout every unfaulted channel follows its direct input pin
// - enabled logic-supply failure makes channels follow their direct input pins
// - both supplies present gives normal; link or supply failure gives fail-safe
// - fail-safe: channels follow parallel inputs, configuration held at defaults
// - 16-bit full duplex words, most significant bit first
// - wake-up is OR of reset pin, wake pin and four input-active signals
// - fail is enabled supply failure, or watchdog timeout with select input open
// - fault is OR of channel flags, undervoltage and qualified overvoltage
// - wake-up low gives sleep mode and all four outputs off
// - wake-up, no fail, no fault gives normal mode, watchdog running if enabled
// - wake-up and fail without fault gives fail-safe mode
// - wake-up and fault gives fault mode; faulted outputs off, autoretry runs
// - after power-up start in sleep and stay there while wake sources low
// - in sleep all configuration bits act as zero
// - normal-mode status bit reads one in normal mode, zero in fail-safe
// - drive: no PWM (in and not disable) or on; PWM on and duty wave
// - fault-clear: no PWM input-active and not disable; else on bit
// - chip select rise writes addressed register; fall loads status word
// - serial input captured on serial clock fall
// - five-bit address field in each command word selects the register
// - serial clock and input ignored while chip select high
package lsc_pkg;

    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned INON_FILT_NS  = 1000;
    localparam int unsigned INON_FILT_CYC =
        (INON_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int unsigned WORD_W  = 16;
    localparam int unsigned ADDR_W  = 5;
    localparam int unsigned DATA_W  = 10;
    localparam int unsigned CH_N    = 4;

    // command word layout
    localparam int unsigned WD_BIT   = 15;
    localparam int unsigned ADDR_LSB = 10;
    localparam int unsigned DATA_LSB = 0;

    localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h01;
    localparam logic [ADDR_W-1:0] ADDR_CFG  = 5'h02;

    // control register fields
    localparam int unsigned CTRL_ON_LSB     = 0;
    localparam int unsigned CTRL_DIRDIS_LSB = 4;
    localparam int unsigned CTRL_PWM_EN     = 8;
    localparam int unsigned CTRL_VDDF_EN    = 9;
    // config register fields
    localparam int unsigned CFG_OVERVOLTAGE_QUALIFIER      = 0;

    localparam logic [DATA_W-1:0] CTRL_RST = 10'h000;
    localparam logic [DATA_W-1:0] CFG_RST  = 10'h000;

    // status word fields
    localparam int unsigned ST_FAIL      = 0;
    localparam int unsigned ST_NM        = 1;
    localparam int unsigned ST_OV        = 2;
    localparam int unsigned ST_UV        = 3;
    localparam int unsigned ST_CHF_LSB   = 4;
    localparam int unsigned ST_OUT_LSB   = 8;
    localparam int unsigned ST_INON_LSB  = 12;

    localparam logic [4:0] BIT_CNT_FULL = 5'h10;

    typedef enum logic [1:0] {
        LSC_SLEEP,
        LSC_NORMAL,
        LSC_FAILSAFE,
        LSC_FAULT
    } lsc_mode_t;

endpackage

/* src/lsc_pin_sync.sv */
// three-stage pin synchroniser with optional stability filter
`timescale 1ns/10ps
`default_nettype none
module lsc_pin_sync #(
    parameter int unsigned W    = 1,
    parameter int unsigned FILT = 1
) (
    input  wire logic         core_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o,
    output logic      [W-1:0] stable_o
);

    localparam int unsigned CW = $clog2(FILT + 1) + 1;
    localparam logic [CW-1:0] CNT_MAX = CW'(FILT);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] level_q;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q    <= '0;
            s2_q    <= '0;
            s3_q    <= '0;
            level_q <= '0;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    level_q[i] <= s3_q[i];
                end
            end
        end
    end

    assign level_o = level_q;

    // =====================================================================
    // stability filter per bit
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_filt
            logic [CW-1:0] cnt_q;
            logic          stab_q;
            always_ff @(posedge core_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    cnt_q  <= '0;
                    stab_q <= 1'b0;
                end else if (level_q[g] == stab_q) begin
                    cnt_q <= '0;
                end else if (cnt_q >= CNT_MAX - CW'(1)) begin
                    cnt_q  <= '0;
                    stab_q <= level_q[g];
                end else begin
                    cnt_q <= cnt_q + CW'(1);
                end
            end
            assign stable_o[g] = stab_q;
        end
    endgenerate

endmodule
`default_nettype wire

/* src/lsc_mode_ctrl.sv */
// mode selection, output control and serial register link of the lamp switch
`timescale 1ns/10ps
`default_nettype none
module lsc_mode_ctrl #(
    parameter int unsigned FILT_CYC = lsc_pkg::INON_FILT_CYC
) (
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    // serial link pins
    input  wire logic       sclk_i,
    input  wire logic       chip_select_n_i,
    input  wire logic       si_i,
    output logic            so_o,
    output logic            so_oe_n_o,
    // wake and direct pins
    input  wire logic       reset_wake_pin_i,
    input  wire logic       wake_i,
    input  wire logic [3:0] in_i,
    input  wire logic       failsafe_select_in_i,
    input  wire logic       vdd_fail_i,
    // supervision and protection inputs
    input  wire logic       wd_timeout_i,
    input  wire logic [3:0] overcurrent_flag_i,
    input  wire logic [3:0] overtemp_flag_i,
    input  wire logic [3:0] severe_short_flag_i,
    input  wire logic       undervoltage_flag_i,
    input  wire logic       overvoltage_flag_i,
    input  wire logic [3:0] duty_wave_i,
    // control outputs
    output logic [3:0]      power_output_channel_o,
    output logic [3:0]      fault_control_o,
    output logic [1:0]      mode_o,
    output logic            normal_mode_flag_o,
    output logic            wd_enable_o,
    output logic            wake_up_o,
    output logic            fail_o,
    output logic            fault_o
);

    // =====================================================================
    // pin synchronisers
    logic [3:0] in_lvl;
    logic [3:0] in_on;
    logic [7:0] misc_lvl;
    logic [7:0] misc_unused;

    lsc_pin_sync #(
        .W    (4),
        .FILT (FILT_CYC)
    ) u_in_sync (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .pin_i      (in_i),
        .level_o    (in_lvl),
        .stable_o   (in_on)
    );

    // chip select enters inverted so the reset value reads as deselected
    lsc_pin_sync #(
        .W    (8),
        .FILT (1)
    ) u_misc_sync (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .pin_i      ({vdd_fail_i, failsafe_select_in_i, wake_i,
                      reset_wake_pin_i, 1'b0, si_i, ~chip_select_n_i,
                      sclk_i}),
        .level_o    (misc_lvl),
        .stable_o   (misc_unused)
    );

    wire sclk_lvl = misc_lvl[0];
    wire csn_lvl  = ~misc_lvl[1];
    wire si_lvl   = misc_lvl[2];
    wire rstp_lvl = misc_lvl[4];
    wire wake_lvl = misc_lvl[5];
    wire fsi_lvl  = misc_lvl[6];
    wire vddf_lvl = misc_lvl[7];

    // =====================================================================
    // edge detection on the link
    logic sclk_prev_q;
    logic csn_prev_q;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_prev_q <= 1'b0;
            csn_prev_q  <= 1'b1;
        end else begin
            sclk_prev_q <= sclk_lvl;
            csn_prev_q  <= csn_lvl;
        end
    end

    wire selected  = ~csn_lvl;
    wire sclk_rise = selected & sclk_lvl & ~sclk_prev_q;
    wire sclk_fall = selected & ~sclk_lvl & sclk_prev_q;
    wire cs_fall   = ~csn_lvl & csn_prev_q;
    wire cs_rise   = csn_lvl & ~csn_prev_q;

    // =====================================================================
    // registers and mode
    lsc_pkg::lsc_mode_t mode_q;
    lsc_pkg::lsc_mode_t mode_d;

    logic [lsc_pkg::DATA_W-1:0] ctrl_q;
    logic [lsc_pkg::DATA_W-1:0] cfg_q;
    logic                       fail_q;

    wire cfg_live    = (mode_q == lsc_pkg::LSC_NORMAL) ||
                       (mode_q == lsc_pkg::LSC_FAULT && !fail_q);
    // sleep and fail-safe see defaults, i.e. zero
    wire [3:0] on_b   = cfg_live ?
        ctrl_q[lsc_pkg::CTRL_ON_LSB +: 4] : 4'h0;
    wire [3:0] dis_b  = cfg_live ?
        ctrl_q[lsc_pkg::CTRL_DIRDIS_LSB +: 4] : 4'h0;
    wire pwm_en       = cfg_live & ctrl_q[lsc_pkg::CTRL_PWM_EN];
    wire vddf_en      = ctrl_q[lsc_pkg::CTRL_VDDF_EN];
    wire overvoltage_qualifier       = cfg_live & cfg_q[lsc_pkg::CFG_OVERVOLTAGE_QUALIFIER];

    wire wd_en        = fsi_lvl;
    wire wake_up      = rstp_lvl | wake_lvl | (|in_on);
    wire fail_cond    = (vddf_lvl & vddf_en) |
                        (wd_timeout_i & wd_en);
    wire [3:0] ch_flt = overcurrent_flag_i | overtemp_flag_i |
                        severe_short_flag_i;
    wire ov_qual      = ~overvoltage_qualifier;
    wire fault        = (|ch_flt) | undervoltage_flag_i |
                        (overvoltage_flag_i & ov_qual);
    wire fail_now     = fail_q | fail_cond;

    always_comb begin
        if (!wake_up) begin
            mode_d = lsc_pkg::LSC_SLEEP;
        end else if (fault) begin
            mode_d = lsc_pkg::LSC_FAULT;
        end else if (fail_now) begin
            mode_d = lsc_pkg::LSC_FAILSAFE;
        end else begin
            mode_d = lsc_pkg::LSC_NORMAL;
        end
    end

    // =====================================================================
    // serial shift logic
    logic [lsc_pkg::WORD_W-1:0] rx_q;
    logic [lsc_pkg::WORD_W-1:0] tx_q;
    logic [4:0]                 bit_cnt_q;
    logic                       so_q;
    logic [3:0]                 out_q;
    logic [3:0]                 fctl_q;

    wire [lsc_pkg::WORD_W-1:0] status_w = {
        in_on, out_q, ch_flt, undervoltage_flag_i, overvoltage_flag_i,
        (mode_q == lsc_pkg::LSC_NORMAL), fail_q};

    wire                       word_ok = cs_rise &&
                                         (bit_cnt_q == lsc_pkg::BIT_CNT_FULL);
    wire [lsc_pkg::ADDR_W-1:0] rx_addr =
        rx_q[lsc_pkg::ADDR_LSB +: lsc_pkg::ADDR_W];
    wire [lsc_pkg::DATA_W-1:0] rx_data =
        rx_q[lsc_pkg::DATA_LSB +: lsc_pkg::DATA_W];
    wire rx_wd     = rx_q[lsc_pkg::WD_BIT];
    wire wr_allow  = word_ok && (mode_q == lsc_pkg::LSC_NORMAL ||
                                 mode_q == lsc_pkg::LSC_FAULT);
    wire wr_ctrl   = wr_allow && (rx_addr == lsc_pkg::ADDR_CTRL);
    wire wr_cfg    = wr_allow && (rx_addr == lsc_pkg::ADDR_CFG);
    wire cfg_clear = (mode_q == lsc_pkg::LSC_SLEEP) ||
                     (mode_q == lsc_pkg::LSC_FAILSAFE);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_q      <= '0;
            bit_cnt_q <= '0;
        end else if (cs_fall) begin
            bit_cnt_q <= '0;
        end else if (sclk_fall) begin
            rx_q      <= {rx_q[lsc_pkg::WORD_W-2:0], si_lvl};
            if (bit_cnt_q != lsc_pkg::BIT_CNT_FULL) begin
                bit_cnt_q <= bit_cnt_q + 5'h01;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_q <= '0;
            so_q <= 1'b0;
        end else if (cs_fall) begin
            tx_q <= status_w;
            so_q <= status_w[lsc_pkg::WORD_W-1];
        end else if (sclk_rise) begin
            so_q <= tx_q[lsc_pkg::WORD_W-1];
            tx_q <= {tx_q[lsc_pkg::WORD_W-2:0], 1'b0};
        end
    end

    assign so_o      = so_q;
    assign so_oe_n_o = csn_lvl;

    // =====================================================================
    // configuration registers and fail latch
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= lsc_pkg::CTRL_RST;
            cfg_q  <= lsc_pkg::CFG_RST;
        end else if (cfg_clear) begin
            ctrl_q <= lsc_pkg::CTRL_RST;
            cfg_q  <= lsc_pkg::CFG_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= rx_data;
            end
            if (wr_cfg) begin
                cfg_q <= rx_data;
            end
        end
    end

    // a new failure wins over the watchdog-bit release
    // live supply failure holds the latch though its enable was cleared
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fail_q <= 1'b0;
        end else if (!wake_up) begin
            fail_q <= 1'b0;
        end else if (fail_cond) begin
            fail_q <= 1'b1;
        end else if (word_ok && rx_wd && !vddf_lvl) begin
            fail_q <= 1'b0;
        end else if (!wd_en && !vddf_lvl) begin
            fail_q <= 1'b0;
        end
    end

    // =====================================================================
    // output drive and fault-clear qualifier
    wire [3:0] hson = pwm_en ? (on_b & duty_wave_i)
                             : ((in_lvl & ~dis_b) | on_b);
    wire [3:0] fctl = pwm_en ? on_b
                             : (in_on & ~dis_b);

    logic [3:0] out_d;
    always_comb begin
        unique case (mode_q)
            lsc_pkg::LSC_SLEEP:    out_d = 4'h0;
            lsc_pkg::LSC_NORMAL:   out_d = hson;
            lsc_pkg::LSC_FAILSAFE: out_d = in_lvl;
            lsc_pkg::LSC_FAULT:    out_d = (fail_q ? in_lvl : hson)
                                           & ~ch_flt;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_q <= lsc_pkg::LSC_SLEEP;
            out_q  <= 4'h0;
            fctl_q <= 4'h0;
        end else begin
            mode_q <= mode_d;
            out_q  <= out_d;
            fctl_q <= (mode_q == lsc_pkg::LSC_SLEEP) ? 4'h0 : fctl;
        end
    end

    assign power_output_channel_o = out_q;
    assign fault_control_o        = fctl_q;
    assign mode_o                 = mode_q;
    assign normal_mode_flag_o     = (mode_q == lsc_pkg::LSC_NORMAL);
    assign wd_enable_o            = wd_en &
                                    (mode_q == lsc_pkg::LSC_NORMAL);
    assign wake_up_o              = wake_up;
    assign fail_o                 = fail_q;
    assign fault_o                = fault;

endmodule
`default_nettype wire

/* testbench/lsc_mode_ctrl_monitor.sv */
// assertion checker of the lamp switch mode control ports
`timescale 1ns/10ps
`default_nettype none
module lsc_mode_ctrl_monitor (
    input wire logic       core_clk_i,
    input wire logic       rst_n_i,
    input wire logic       chip_select_n_i,
    input wire logic       failsafe_select_in_i,
    input wire logic [3:0] overcurrent_flag_i,
    input wire logic [3:0] overtemp_flag_i,
    input wire logic [3:0] severe_short_flag_i,
    input wire logic       undervoltage_flag_i,
    input wire logic       so_oe_n_o,
    input wire logic [3:0] power_output_channel_o,
    input wire logic [3:0] fault_control_o,
    input wire logic [1:0] mode_o,
    input wire logic       normal_mode_flag_o,
    input wire logic       wd_enable_o,
    input wire logic       wake_up_o,
    input wire logic       fail_o,
    input wire logic       fault_o
);
    // ==========================
    // link, mode and output checks
    default clocking mon_cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    so_release_a: assert property (
        chip_select_n_i [*6] |-> so_oe_n_o)
        else $error("serial output driven while deselected");
    so_enable_a: assert property (
        $fell(chip_select_n_i) |-> ##[1:8] !so_oe_n_o)
        else $error("serial output not driven after select");
    sleep_mode_a: assert property (
        !wake_up_o |=> mode_o == 2'h0)
        else $error("not asleep without wake-up");
    sleep_off_a: assert property (
        mode_o == 2'h0 |=> power_output_channel_o == 4'h0
            && fault_control_o == 4'h0)
        else $error("channel active in sleep");
    fault_mode_a: assert property (
        wake_up_o && fault_o |=> mode_o == 2'h3)
        else $error("fault mode missed");
    failsafe_mode_a: assert property (
        wake_up_o && !fault_o && fail_o ##1 fail_o |-> mode_o == 2'h2)
        else $error("fail-safe mode missed");
    normal_mode_a: assert property (
        wake_up_o && !fault_o && !fail_o ##1 !fail_o |-> mode_o == 2'h1)
        else $error("normal mode missed");
    nm_flag_a: assert property (
        normal_mode_flag_o == (mode_o == 2'h1))
        else $error("normal flag disagrees with mode");
    wd_normal_a: assert property (
        wd_enable_o |-> mode_o == 2'h1)
        else $error("watchdog enabled outside normal mode");
    wd_off_a: assert property (
        !failsafe_select_in_i [*5] |-> !wd_enable_o)
        else $error("watchdog enabled with select grounded");
    fault_cond_a: assert property (
        (|{overcurrent_flag_i, overtemp_flag_i, severe_short_flag_i,
           undervoltage_flag_i}) |-> ##[0:1] fault_o)
        else $error("fault condition missed");
endmodule

bind lsc_mode_ctrl lsc_mode_ctrl_monitor i_lsc_mode_ctrl_monitor (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .chip_select_n_i(chip_select_n_i),
    .failsafe_select_in_i(failsafe_select_in_i),
    .overcurrent_flag_i(overcurrent_flag_i),
    .overtemp_flag_i(overtemp_flag_i),
    .severe_short_flag_i(severe_short_flag_i),
    .undervoltage_flag_i(undervoltage_flag_i), .so_oe_n_o(so_oe_n_o),
    .power_output_channel_o(power_output_channel_o),
    .fault_control_o(fault_control_o), .mode_o(mode_o),
    .normal_mode_flag_o(normal_mode_flag_o), .wd_enable_o(wd_enable_o),
    .wake_up_o(wake_up_o), .fail_o(fail_o), .fault_o(fault_o)
);
`default_nettype wire

/* testbench/lsc_spi_host.sv */
// serial link master model standing in for the host controller
`timescale 1ns/10ps
`default_nettype none
module lsc_spi_host (
    output logic     sclk_o,
    output logic     chip_select_n_o,
    output logic     si_o,
    input wire logic so_i,
    input wire logic so_oe_n_i
);
    // ==========================
    // one full duplex word
    initial begin
        sclk_o          = 1'b0;
        chip_select_n_o = 1'b1;
        si_o            = 1'b0;
    end

    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        #1.7;
        chip_select_n_o = 1'b0;
        #100;
        for (int k = 15; k >= 0; k--) begin
            sclk_o = 1'b1;
            si_o   = tx[k];
            #80;
            rx[k]  = so_oe_n_i ? 1'bz : so_i;
            sclk_o = 1'b0;
            #80;
        end
        chip_select_n_o = 1'b1;
        si_o            = ~si_o;
        #400;
    endtask
endmodule
`default_nettype wire

/* testbench/test_lsc_mode_ctrl.sv */
// self-checking bench of the lamp switch mode control block
`timescale 1ns/10ps
`default_nettype none
module test_lsc_mode_ctrl;
    logic        core_clk_i = 1'b0;
    logic        rst_n_i    = 1'b0;
    logic        rwp        = 1'b0;
    logic        wake       = 1'b0;
    logic [3:0]  in_p       = 4'h0;
    logic        fs_sel     = 1'b1;
    logic        vddf       = 1'b0;
    logic        wdto       = 1'b0;
    logic [11:0] flg        = 12'h000;
    logic        underv     = 1'b0;
    logic        overv      = 1'b0;
    logic [3:0]  duty       = 4'h0;
    logic        sclk, cs_n, si, so, soe, nmf, wde, wku, fl, flt;
    logic [3:0]  pwr, fcl;
    logic [1:0]  md;
    logic [15:0] rx;
    int          error_cnt   = 0;
    int          check_count = 0;

    initial begin
        forever #2 core_clk_i = ~core_clk_i;
    end

    lsc_mode_ctrl #(.FILT_CYC(4)) i_lsc_mode_ctrl (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk),
        .chip_select_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_n_o(soe),
        .reset_wake_pin_i(rwp), .wake_i(wake), .in_i(in_p),
        .failsafe_select_in_i(fs_sel), .vdd_fail_i(vddf),
        .wd_timeout_i(wdto), .overcurrent_flag_i(flg[3:0]),
        .overtemp_flag_i(flg[7:4]), .severe_short_flag_i(flg[11:8]),
        .undervoltage_flag_i(underv), .overvoltage_flag_i(overv),
        .duty_wave_i(duty), .power_output_channel_o(pwr),
        .fault_control_o(fcl), .mode_o(md), .normal_mode_flag_o(nmf),
        .wd_enable_o(wde), .wake_up_o(wku), .fail_o(fl), .fault_o(flt)
    );

    lsc_spi_host i_lsc_spi_host (
        .sclk_o(sclk), .chip_select_n_o(cs_n), .si_o(si),
        .so_i(so), .so_oe_n_i(soe)
    );

    // ==========================
    // access and compare tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    task automatic wr(input logic [4:0] a, input logic [9:0] d);
        i_lsc_spi_host.xfer({1'b0, a, d}, rx);
        cyc(4);
    endtask

    task automatic ck(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #300000;
        error_cnt++;
        give_verdict();
    end

    // ==========================
    // test sequence
    initial begin
        repeat (5) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        cyc(8);
        ck(16'(md), 16'h0);
        wr(lsc_pkg::ADDR_CTRL, 10'h00f);
        ck(16'(pwr), 16'h0);
        @(posedge core_clk_i) rwp <= 1'b1;
        cyc(10);
        ck(16'(md), 16'h1);
        ck(16'(pwr), 16'h0);
        ck(16'(wde), 16'h1);
        $display("test sleep done");
        wr(lsc_pkg::ADDR_CTRL, 10'h005);
        ck(16'(pwr), 16'h5);
        i_lsc_spi_host.xfer(16'h0000, rx);
        ck(rx, 16'h0502);
        wr(lsc_pkg::ADDR_CTRL, 10'h020);
        @(posedge core_clk_i) in_p <= 4'hf;
        cyc(24);
        ck(16'(pwr), 16'hd);
        ck(16'(fcl), 16'hd);
        wr(lsc_pkg::ADDR_CTRL, 10'h103);
        @(posedge core_clk_i) duty <= 4'h6;
        cyc(6);
        ck(16'(pwr), 16'h2);
        ck(16'(fcl), 16'h3);
        $display("test drive done");
        wr(lsc_pkg::ADDR_CTRL, 10'h003);
        @(posedge core_clk_i) in_p <= 4'h0;
        for (int k = 0; k < 4; k++) begin
            @(posedge core_clk_i);
            if (k < 3) flg <= 12'h002 << (4 * k);
            else underv <= 1'b1;
            cyc(24);
            ck(16'(md), 16'h3);
            if (k < 3) ck(16'(pwr), 16'h1);
            @(posedge core_clk_i) {flg, underv} <= 13'h0000;
            cyc(8);
            ck(16'(md), 16'h1);
        end
        @(posedge core_clk_i) overv <= 1'b1;
        cyc(4);
        ck(16'(flt), 16'h1);
        wr(lsc_pkg::ADDR_CFG, 10'h001);
        ck({flt, 13'h0000, md}, 16'h0001);
        @(posedge core_clk_i) overv <= 1'b0;
        $display("test fault done");
        @(posedge core_clk_i) in_p <= 4'h9;
        @(posedge core_clk_i) wdto <= 1'b1;
        @(posedge core_clk_i) wdto <= 1'b0;
        cyc(24);
        ck({fl, nmf, wde, 11'h000, md}, 16'h8002);
        ck(16'(pwr), 16'h9);
        i_lsc_spi_host.xfer(16'h0000, rx);
        ck(rx, 16'h9901);
        i_lsc_spi_host.xfer(16'h8000, rx);
        cyc(8);
        ck(16'(md), 16'h1);
        $display("test watchdog done");
        @(posedge core_clk_i) fs_sel <= 1'b0;
        cyc(8);
        ck(16'(wde), 16'h0);
        @(posedge core_clk_i) wdto <= 1'b1;
        cyc(4);
        ck(16'(fl), 16'h0);
        @(posedge core_clk_i) wdto <= 1'b0;
        wr(lsc_pkg::ADDR_CTRL, 10'h200);
        @(posedge core_clk_i) vddf <= 1'b1;
        cyc(24);
        ck({pwr, 10'h000, md}, 16'h9002);
        @(posedge core_clk_i) vddf <= 1'b0;
        i_lsc_spi_host.xfer(16'h8000, rx);
        cyc(8);
        ck(16'(md), 16'h1);
        $display("test supply done");
        @(posedge core_clk_i) rwp <= 1'b0;
        cyc(4);
        ck(16'(wku), 16'h1);
        @(posedge core_clk_i) {wake, in_p} <= 5'h10;
        cyc(30);
        ck(16'(wku), 16'h1);
        @(posedge core_clk_i) wake <= 1'b0;
        cyc(8);
        ck({pwr, fcl, 6'h00, md}, 16'h0000);
        $display("test sleep return done");
        give_verdict();
    end
endmodule
`default_nettype wire
